// file: fcd_pkg.sv
// package: fuse decoder constants, types and register map
package fcd_pkg;

  // ==========================================================
  // register map (printed offsets not word aligned: index*4)
  localparam logic [3:0] FCD_IDX_SYS_CFG_ZERO = 4'h5;
  localparam logic [3:0] FCD_IDX_SYS_CFG_ONE = 4'h6;
  localparam logic [3:0] FCD_IDX_APP_END = 4'h7;
  localparam logic [3:0] FCD_IDX_BOOT_END = 4'h8;
  localparam logic [3:0] FCD_IDX_LOCK = 4'hA;
  localparam logic [3:0] FCD_IDX_STATUS = 4'hB;
  localparam logic [3:0] FCD_IDX_CHIPERASE = 4'hC;
  localparam int FCD_NUM_FUSES = 11;

  // ==========================================================
  // field positions
  localparam int FCD_CRC_LSB = 6;
  localparam int FCD_PIN_LSB = 2;
  localparam int FCD_KEEP_EE_BIT = 0;

  // ==========================================================
  // values and reset
  localparam logic [7:0] FCD_UNLOCK_KEY = 8'hC5;
  localparam logic [7:0] FCD_ZERO_BYTE = 8'h00;
  localparam logic [31:0] FCD_ZERO_WORD = 32'h0000_0000;

  // ==========================================================
  // timing: 20 MHz core, slow rc at 32768 Hz
  localparam int FCD_CLK_HZ = 20000000;
  localparam int FCD_SLOW_HZ = 32768;
  localparam int FCD_GPIO_HOLD_SLOW = 768;
  // 768 slow cycles rounded up to core cycles; both rates scaled by 256
  // so the product fits an int without losing precision
  localparam int FCD_GPIO_HOLD_CYC =
    (FCD_GPIO_HOLD_SLOW * (FCD_CLK_HZ / 256) + (FCD_SLOW_HZ / 256) - 1)
    / (FCD_SLOW_HZ / 256);
  localparam int FCD_MS_CYC = FCD_CLK_HZ / 1000;
  localparam int FCD_MAX_DELAY_MS = 64;

  typedef enum logic [1:0] {
    FCD_CRC_FLASH = 2'h0,
    FCD_CRC_BOOT = 2'h1,
    FCD_CRC_BOOT_APP = 2'h2,
    FCD_CRC_NONE = 2'h3
  } fcd_crc_t;

  typedef enum logic [1:0] {
    FCD_PIN_GPIO = 2'h0,
    FCD_PIN_DEBUG = 2'h1,
    FCD_PIN_RESET = 2'h2,
    FCD_PIN_RSVD = 2'h3
  } fcd_pin_t;

  // loader states, gray along load path
  typedef enum logic [1:0] {
    FCD_ST_LOAD = 2'b00,
    FCD_ST_WAIT = 2'b01,
    FCD_ST_RUN = 2'b11
  } fcd_state_t;

  // decoded partition in 256-byte blocks
  typedef struct packed {
    logic all_boot;
    logic [7:0] boot_end_blk;
    logic [7:0] app_end_blk;
    logic app_to_top;
  } fcd_part_t;

endpackage

// file: fcd_fuse_mem.sv
// fuse byte array with registered read port
module fcd_fuse_mem
  import fcd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_reg [FCD_NUM_FUSES];

  // ==========================================================
  // storage and read register
  always_ff @(posedge i_clk) begin
    if (i_we && (i_addr < 4'(FCD_NUM_FUSES))) begin
      mem_reg[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= FCD_ZERO_BYTE;
    end else if (i_addr < 4'(FCD_NUM_FUSES)) begin
      o_rdata <= mem_reg[i_addr];
    end else begin
      o_rdata <= FCD_ZERO_BYTE;
    end
  end

endmodule

// file: fcd_fuse_decoder.sv
// fuse configuration decoder with ahb-lite register slave
// Function
// - flash check source field goes to the crc scanner at reset.
// - reset pin function selects gpio, debug port or reset input.
// - in gpio mode the pin driver stays off 768 slow rc cycles.
// - retention bit picks eeprom erase or keep on chip erase.
// - a locked device always erases eeprom on chip erase; the code ignores chip erase until config is valid.
// - start-up delay code n waits 0 ms or 2^(n-1) ms.
// - app end field places code end in 256-byte blocks.
// - app end zero makes all flash above boot end app code.
// - boot end field places boot end in 256-byte blocks.
// - boot end zero makes the whole flash boot section.
// - only key 0xC5 unlocks; other keys lock the device.
// - locked device denies debug port bus access but info block; the code has no info block and denies all debug bus access.
// - fuse bits are copied to peripheral config at start-up.
//
// Implementation choice: the AHB-Lite interface to the registers.
module fcd_fuse_decoder
  import fcd_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_CHIP_ERASE,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic O_CONFIG_VALID,
  output logic [1:0] O_FLASH_CHECK_SOURCE,
  output logic [1:0] O_RESET_PIN_FUNCTION,
  output logic O_PIN_DRIVER_ENABLE,
  output logic O_CODE_START,
  output logic [7:0] O_BOOT_END_BLK,
  output logic [7:0] O_APP_END_BLK,
  output logic O_ALL_BOOT,
  output logic O_APP_TO_TOP,
  output logic O_LOCKED,
  output logic O_DEBUG_BUS_ALLOW,
  output logic O_ERASE_EEPROM
);

  // assertion clock and reset for the whole module
  default clocking fcd_cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // ==========================================================
  // ahb address phase capture
  logic wr_pend_reg, rd_pend_reg;
  logic [3:0] idx_reg;
  wire logic xfer = I_HSEL && I_HTRANS[1] && I_HREADY;
  wire logic [3:0] a_idx = I_HADDR[5:2];

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 4'h0;
    end else begin
      wr_pend_reg <= xfer && I_HWRITE;
      rd_pend_reg <= xfer && !I_HWRITE;
      idx_reg <= xfer ? a_idx : idx_reg;
    end
  end

  // ==========================================================
  // fuse array: loader and lock key write share the port
  fcd_state_t state_reg, state_next;
  logic [3:0] ld_idx_reg;
  logic [7:0] mem_rdata;
  logic [7:0] fz0_reg, fz1_reg, app_reg, boot_reg, key_reg;
  wire logic loading = (state_reg == FCD_ST_LOAD);
  // only the lock key is writable by software
  wire logic key_wr = wr_pend_reg && (idx_reg == FCD_IDX_LOCK);
  wire logic [3:0] mem_addr = loading ? ld_idx_reg : a_idx;

  fcd_fuse_mem u_mem (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_addr(key_wr ? FCD_IDX_LOCK : mem_addr),
    .i_we(key_wr),
    .i_wdata(I_HWDATA[7:0]),
    .o_rdata(mem_rdata)
  );

  // ==========================================================
  // loader: one pass per reset, then wait on start-up delay
  logic [3:0] cap_idx_reg;
  logic cap_vld_reg;
  logic [31:0] wait_reg;
  wire logic ld_last = (ld_idx_reg == 4'(FCD_NUM_FUSES - 1));
  wire logic [2:0] delay_sel = fz1_reg[2:0];
  // code 0 -> 0 ms, else 2^(n-1) ms
  wire logic [31:0] delay_cyc = (delay_sel == 3'h0) ? FCD_ZERO_WORD :
    32'(FCD_MS_CYC) << (delay_sel - 3'h1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FCD_ST_LOAD: state_next = (cap_vld_reg && cap_idx_reg ==
        4'(FCD_NUM_FUSES - 1)) ? FCD_ST_WAIT : FCD_ST_LOAD;
      FCD_ST_WAIT: state_next = (wait_reg >= delay_cyc) ? FCD_ST_RUN :
        FCD_ST_WAIT;
      FCD_ST_RUN: state_next = FCD_ST_RUN;
      default: state_next = FCD_ST_LOAD;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= FCD_ST_LOAD;
      ld_idx_reg <= 4'h0;
      cap_idx_reg <= 4'h0;
      cap_vld_reg <= 1'b0;
      wait_reg <= FCD_ZERO_WORD;
    end else begin
      state_reg <= state_next;
      // a key write steals the port: hold the index so no fuse is skipped
      ld_idx_reg <= (loading && !ld_last && !key_wr) ? ld_idx_reg + 4'h1 :
        ld_idx_reg;
      cap_idx_reg <= ld_idx_reg;
      cap_vld_reg <= loading && !key_wr;
      wait_reg <= (state_reg == FCD_ST_WAIT) ? wait_reg + 32'h0000_0001 :
        FCD_ZERO_WORD;
    end
  end

  // ==========================================================
  // holding registers, captured once during load
  wire logic cap = loading && cap_vld_reg;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fz0_reg <= FCD_ZERO_BYTE;
      fz1_reg <= FCD_ZERO_BYTE;
      app_reg <= FCD_ZERO_BYTE;
      boot_reg <= FCD_ZERO_BYTE;
      key_reg <= FCD_ZERO_BYTE;
    end else if (cap) begin
      if (cap_idx_reg == FCD_IDX_SYS_CFG_ZERO) fz0_reg <= mem_rdata;
      if (cap_idx_reg == FCD_IDX_SYS_CFG_ONE) fz1_reg <= mem_rdata;
      if (cap_idx_reg == FCD_IDX_APP_END) app_reg <= mem_rdata;
      if (cap_idx_reg == FCD_IDX_BOOT_END) boot_reg <= mem_rdata;
      if (cap_idx_reg == FCD_IDX_LOCK) key_reg <= mem_rdata;
    end
  end

  // ==========================================================
  // decode of captured fuses
  wire logic locked = (key_reg != FCD_UNLOCK_KEY);
  wire logic gpio_mode = (fz0_reg[FCD_PIN_LSB +: 2] == FCD_PIN_GPIO);
  wire logic keep_ee = fz0_reg[FCD_KEEP_EE_BIT];
  wire logic all_boot = (boot_reg == FCD_ZERO_BYTE);
  wire logic app_top = !all_boot && (app_reg == FCD_ZERO_BYTE);
  wire logic running = (state_reg == FCD_ST_RUN);

  // partition bounds bundled for the flash units
  fcd_part_t part;
  assign part = '{all_boot: all_boot, boot_end_blk: boot_reg,
    app_end_blk: app_reg, app_to_top: app_top};

  // gpio driver hold after every reset
  // hold needs 19 bits: the count exceeds 18-bit range
  logic [18:0] hold_reg;
  wire logic hold_done = (hold_reg >= 19'(FCD_GPIO_HOLD_CYC));
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hold_reg <= 19'h0_0000;
    end else if (!hold_done) begin
      hold_reg <= hold_reg + 19'h0_0001;
    end
  end

  // ==========================================================
  // registered outputs
  wire logic cfg_ok = (state_reg != FCD_ST_LOAD);
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CONFIG_VALID <= 1'b0;
      O_FLASH_CHECK_SOURCE <= FCD_CRC_NONE;
      O_RESET_PIN_FUNCTION <= FCD_PIN_RESET;
      O_PIN_DRIVER_ENABLE <= 1'b0;
      O_CODE_START <= 1'b0;
      O_BOOT_END_BLK <= FCD_ZERO_BYTE;
      O_APP_END_BLK <= FCD_ZERO_BYTE;
      O_ALL_BOOT <= 1'b1;
      O_APP_TO_TOP <= 1'b0;
      O_LOCKED <= 1'b1;
      O_DEBUG_BUS_ALLOW <= 1'b0;
      O_ERASE_EEPROM <= 1'b0;
    end else begin
      O_CONFIG_VALID <= cfg_ok;
      O_FLASH_CHECK_SOURCE <= fz0_reg[FCD_CRC_LSB +: 2];
      O_RESET_PIN_FUNCTION <= fz0_reg[FCD_PIN_LSB +: 2];
      O_PIN_DRIVER_ENABLE <= cfg_ok && gpio_mode && hold_done;
      O_CODE_START <= running;
      O_BOOT_END_BLK <= part.boot_end_blk;
      O_APP_END_BLK <= part.app_end_blk;
      O_ALL_BOOT <= part.all_boot;
      O_APP_TO_TOP <= part.app_to_top;
      O_LOCKED <= !cfg_ok || locked;
      O_DEBUG_BUS_ALLOW <= cfg_ok && !locked;
      // erase pulse: locked forces eeprom erase
      O_ERASE_EEPROM <= I_CHIP_ERASE && cfg_ok &&
        (locked || !keep_ee);
    end
  end

  // ==========================================================
  // bus read mux and response
  wire logic [7:0] status_byte = {4'h0, O_PIN_DRIVER_ENABLE, locked,
    running, cfg_ok};
  // fuse reads show held copies; unmapped reads return zero
  // decoded in the address phase so the data phase is zero wait
  wire logic [7:0] rd_byte =
    (a_idx == FCD_IDX_SYS_CFG_ZERO) ? fz0_reg :
    (a_idx == FCD_IDX_SYS_CFG_ONE) ? fz1_reg :
    (a_idx == FCD_IDX_APP_END) ? app_reg :
    (a_idx == FCD_IDX_BOOT_END) ? boot_reg :
    (a_idx == FCD_IDX_LOCK) ? key_reg :
    (a_idx == FCD_IDX_STATUS) ? status_byte : FCD_ZERO_BYTE;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_HRDATA <= FCD_ZERO_WORD;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      O_HRDATA <= {24'h00_0000, (xfer && !I_HWRITE) ? rd_byte :
        FCD_ZERO_BYTE};
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  // load finished: the wait state follows the load state
  sequence s_load_end;
    (state_reg == FCD_ST_LOAD) ##1 (state_reg == FCD_ST_WAIT);
  endsequence
  // config valid shows one cycle after the load ends
  sequence s_valid_up;
    ##1 O_CONFIG_VALID;
  endsequence
  // start-up wait not yet elapsed
  sequence s_wait_busy;
    (state_reg == FCD_ST_WAIT) && (wait_reg < delay_cyc);
  endsequence

  a_lock_key: assert property (
    running |-> ##1 (O_DEBUG_BUS_ALLOW == (key_reg == 8'hC5)))
    else $error("debug access does not follow lock key");
  a_locked_erase: assert property (
    (I_CHIP_ERASE && cfg_ok && locked) |=> O_ERASE_EEPROM)
    else $error("locked chip erase kept eeprom");
  a_keep_eeprom_on_erase_keep: assert property (
    (cfg_ok && !locked && keep_ee) |=> !O_ERASE_EEPROM)
    else $error("eeprom erased while retained");
  a_pin_hold: assert property (
    (hold_reg < 19'(FCD_GPIO_HOLD_CYC)) |=> !O_PIN_DRIVER_ENABLE)
    else $error("pin driver on during hold");
  a_hold_frozen: assert property (
    running |=> $stable(key_reg) && $stable(fz0_reg))
    else $error("held fuses changed after load");
  a_all_boot: assert property (
    (boot_reg == 8'h00) |=> O_ALL_BOOT && !O_APP_TO_TOP)
    else $error("zero boot end not whole boot");
  a_app_top: assert property (
    (boot_reg != 8'h00 && app_reg == 8'h00) |=> O_APP_TO_TOP)
    else $error("zero app end not to top");
  a_crc_src: assert property (
    cfg_ok |=> O_FLASH_CHECK_SOURCE == $past(fz0_reg[7:6]))
    else $error("check source mismatch");
  a_pin_func: assert property (
    cfg_ok |=> O_RESET_PIN_FUNCTION == $past(fz0_reg[3:2]))
    else $error("pin function mismatch");
  a_no_delay: assert property (
    (state_reg == FCD_ST_WAIT && delay_sel == 3'h0) |=> running)
    else $error("zero delay not immediate");
  a_boot_blk: assert property (
    running |=> O_BOOT_END_BLK == $past(boot_reg) &&
    O_APP_END_BLK == $past(app_reg))
    else $error("partition bounds mismatch");
  a_load_valid: assert property (
    s_load_end |-> s_valid_up)
    else $error("config valid late after load");
  a_wait_halt: assert property (
    s_wait_busy |=> !running && !O_CODE_START)
    else $error("code started before delay elapsed");
  a_erase_clear: assert property (
    (I_CHIP_ERASE && cfg_ok && !locked && !keep_ee) |=> O_ERASE_EEPROM)
    else $error("eeprom kept without retention");
  a_erase_idle: assert property (
    !I_CHIP_ERASE |=> !O_ERASE_EEPROM)
    else $error("eeprom erase without chip erase");
  a_debug_deny: assert property (
    O_LOCKED |-> !O_DEBUG_BUS_ALLOW)
    else $error("debug bus open while locked");
  a_key_read: assert property (
    (xfer && !I_HWRITE && a_idx == FCD_IDX_LOCK) |=>
    (O_HRDATA[7:0] == $past(key_reg)))
    else $error("lock key readback mismatch");
  a_gpio_only: assert property (
    (O_RESET_PIN_FUNCTION != FCD_PIN_GPIO) |-> !O_PIN_DRIVER_ENABLE)
    else $error("pin driver on outside gpio mode");
  a_crc_hold: assert property (
    running |=> $stable(O_FLASH_CHECK_SOURCE))
    else $error("check source changed after load");

endmodule

// file: fcd_fuse_decoder_tb.sv
// testbench: fuse decoder driven over ahb-lite with preloaded fuses
module fcd_fuse_decoder_tb
  import fcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // stimulus and design outputs
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic erase = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready, hresp, valid, pin_en, code_start, all_boot, app_top;
  logic locked, dbg, erase_ee;
  logic [1:0] fcs, rpf;
  logic [7:0] boot_end, app_end;
  logic [7:0] bes [4] = '{8'h00, 8'h10, 8'h04, 8'hFF};
  logic [7:0] aps [4] = '{8'h00, 8'h00, 8'h20, 8'h01};
  logic [7:0] keys [4] = '{8'hC5, 8'h00, 8'hC4, 8'hC5};
  logic [1:0] crc, pin;
  logic ee, lk;
  logic [31:0] rd;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  fcd_fuse_decoder uut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .I_CHIP_ERASE(erase),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_CONFIG_VALID(valid), .O_FLASH_CHECK_SOURCE(fcs),
    .O_RESET_PIN_FUNCTION(rpf), .O_PIN_DRIVER_ENABLE(pin_en),
    .O_CODE_START(code_start), .O_BOOT_END_BLK(boot_end),
    .O_APP_END_BLK(app_end), .O_ALL_BOOT(all_boot),
    .O_APP_TO_TOP(app_top), .O_LOCKED(locked),
    .O_DEBUG_BUS_ALLOW(dbg), .O_ERASE_EEPROM(erase_ee)
  );

  // ==========================================================
  // clock and hang guard
  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single word transfer, waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // preload fuses, reset 20 cycles, wait for the load to finish
  task automatic boot(input logic [7:0] s0, input logic [7:0] s1,
                      input logic [7:0] ap, input logic [7:0] be,
                      input logic [7:0] key, input logic set_key);
    @(posedge clk);
    rst_n <= 1'b0;
    uut.u_mem.mem_reg[FCD_IDX_SYS_CFG_ZERO] = s0;
    uut.u_mem.mem_reg[FCD_IDX_SYS_CFG_ONE] = s1;
    uut.u_mem.mem_reg[FCD_IDX_APP_END] = ap;
    uut.u_mem.mem_reg[FCD_IDX_BOOT_END] = be;
    if (set_key) begin
      uut.u_mem.mem_reg[FCD_IDX_LOCK] = key;
    end
    repeat (20) @(posedge clk);
    chk({hready, hresp, locked, all_boot, fcs, rpf, valid, erase_ee},
        10'b1_0_1_1_11_10_0_0);
    rst_n <= 1'b1;
    n = 0;
    while (valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(valid, 1'b1);
  endtask

  // one-cycle erase request, result one cycle later
  task automatic erase_pulse();
    @(posedge clk);
    erase <= 1'b1;
    @(posedge clk);
    erase <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      crc = 2'(3 - i);
      pin = 2'(i);
      ee = i[0];
      lk = (keys[i] != FCD_UNLOCK_KEY);
      boot({crc, 2'b00, pin, 1'b0, ee}, 8'h00, aps[i], bes[i],
           keys[i], 1'b1);
      chk(fcs, crc);
      chk(rpf, pin);
      chk(boot_end, bes[i]);
      chk(app_end, aps[i]);
      chk(all_boot, bes[i] == 8'h00);
      if (bes[i] != 8'h00) begin
        chk(app_top, aps[i] == 8'h00);
      end
      chk(locked, lk);
      chk(dbg, !lk);
      n = 0;
      while (code_start !== 1'b1 && n < 10) begin
        @(posedge clk);
        n++;
      end
      chk(code_start, 1'b1);
      chk(pin_en, 1'b0);
      ahb(1'b0, 32'h0000_002C, 32'h0000_0000, rd);
      chk(rd, {28'h0, 1'b0, lk, 2'b11});
      erase_pulse();
      chk(erase_ee, lk | !ee);
    end
    ahb(1'b0, 32'h0000_0014, 32'h0000_0000, rd);
    chk(rd, 32'h0000_000D);
    ahb(1'b0, 32'h0000_003C, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);

    // gpio pin, 1 ms start-up, key rewritten after start-up
    boot(8'h00, 8'h01, 8'h00, 8'h10, FCD_UNLOCK_KEY, 1'b1);
    n = 0;
    while (code_start !== 1'b1 && n < 25000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= FCD_MS_CYC - 16 && n <= FCD_MS_CYC + 16, 1'b1);
    chk(pin_en, 1'b0);
    ahb(1'b1, 32'h0000_0028, 32'h0000_0000, rd);
    ahb(1'b1, 32'h0000_0014, 32'h0000_00C0, rd);
    ahb(1'b0, 32'h0000_0014, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0028, 32'h0000_0000, rd);
    chk(rd, 32'h0000_00C5);
    chk(locked, 1'b0);
    chk(dbg, 1'b1);
    boot(8'h01, 8'h00, 8'h00, 8'h10, 8'h00, 1'b0);
    chk(locked, 1'b1);
    chk(dbg, 1'b0);
    erase_pulse();
    chk(erase_ee, 1'b1);
    tally_and_finish();
  end
endmodule
